// [rtl/pesi_pkg.sv]
// Constants for the per-port event status and interrupt block.
// Assumes an AHB-Lite master with 32-bit word accesses only.
package pesi_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_EN     = 8'h00;
	localparam logic [7:0] OFS_TXS    = 8'h04;
	localparam logic [7:0] OFS_RXS    = 8'h08;
	localparam logic [7:0] OFS_INT    = 8'h0c;
	localparam logic [7:0] OFS_TXPOL  = 8'h10;
	localparam logic [7:0] OFS_RXPOL  = 8'h14;
	localparam logic [7:0] OFS_MODE   = 8'h18;
	localparam logic [7:0] OFS_MAXLEN = 8'h1c;
	// Interrupt enable and status bit positions
	localparam int unsigned B_STOP = 6;
	localparam int unsigned B_OVFC = 5;
	localparam int unsigned B_LNCH = 4;
	localparam int unsigned B_TRANSMIT_FAULT_SUMMARY = 3;
	localparam int unsigned B_TXOK = 2;
	localparam int unsigned B_RECEIVE_EVENT_SUMMARY = 1;
	localparam int unsigned B_RXOK = 0;
	// Transmit status fields
	localparam int unsigned TX_CNT_LSB = 6;
	localparam int unsigned TX_XCL     = 2;
	localparam int unsigned TX_LCL     = 1;
	localparam int unsigned TX_UNF     = 0;
	// Receive status fields
	localparam int unsigned RX_PAUSE = 7;
	localparam int unsigned RX_MEDIA = 5;
	localparam int unsigned RX_LONG  = 4;
	localparam int unsigned RX_RUNT  = 3;
	localparam int unsigned RX_ALIGN = 2;
	localparam int unsigned RX_CRC   = 1;
	localparam int unsigned RX_OVR   = 0;
	// Masks of implemented bits
	localparam logic [7:0] EN_MASK  = 8'h7f;
	localparam logic [7:0] RXS_MASK = 8'hbf;
	localparam logic [2:0] TXS_ERR  = 3'h7;
	// Reset values and limits
	localparam logic [7:0]  RST_BYTE   = 8'h00;
	localparam logic [15:0] RST_MAXLEN = 16'h05ee;
	localparam logic [15:0] RUNT_LEN   = 16'h0040;
	localparam logic [4:0]  XCOL_LAST  = 5'h0f;
	localparam logic [1:0]  TX_CNT_MAX = 2'h2;
endpackage

// [rtl/pesi_port_events.sv]
// Per-port transmit/receive event status, enables and interrupt request.
// Assumes event inputs are one-cycle pulses synchronous to hclk.
// Summary of operation
// - Each enable bit gates only its own event, bits 3,1 only its interrupt; bit 7 reserved.
// - Enable bits 6,5,4: port stop, counter overflow, link change.
// - Enable bits 3,2: transmit error, transmit done.
// - Enable bits 1,0: receive event, receive done.
// - Reading transmit status clears error bits, packet count kept.
// - Transmit error bit sets only if policy stops on that error.
// - Bits 7:6 report transmit FIFO packets, at most 2.
// - Count rises on first byte loaded, falls after packet sent.
// - Bit 2 set after 16 consecutive collided attempts.
// - Bit 1 set on collision after 64 bytes sent.
// - Bit 0 set on FIFO underrun after 64 bytes sent.
// - Reading receive status clears all its bits.
// - Receive status bit sets only if policy passes that event.
// - Any non-passed event in a packet blocks all status bits.
// - Receive status byte pushed to FIFO right after packet end.
// - Bit 7 flags pause frame; bit 6 reserved.
// - Bit 5: symbol error in symbol mode, media error input otherwise.
// - Bit 4: packet longer than configured maximum.
// - Bit 3: packet shorter than 64 bytes.
// - Bit 2: checksum plus framing error.
// - Bit 1: checksum error without framing error.
// - Bit 0: receive FIFO ran out of space during reception.
// - Transmit error summary is OR of transmit error bits.
// - Receive event summary is OR of receive bits, after packet end.
// - Summary bits clear only by reading their status register.
module pesi_port_events (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        port_stopped,
	input  wire logic        counter_saturated,
	input  wire logic        link_changed,
	input  wire logic        tx_first_byte_load,
	input  wire logic        tx_packet_done,
	input  wire logic        tx_collision,
	input  wire logic        tx_past_64_bytes,
	input  wire logic        tx_fifo_starved,
	input  wire logic        rx_active,
	input  wire logic        rx_symbol_err,
	input  wire logic        rx_mii_err,
	input  wire logic        rx_fifo_no_space,
	input  wire logic        rx_frame_end,
	input  wire logic        rx_pause_frame,
	input  wire logic        rx_crc_err,
	input  wire logic        rx_framing_err,
	input  wire logic [15:0] rx_length,
	output logic             rx_status_push,
	output logic      [7:0]  rx_status_byte,
	output logic             port_irq
);
	logic [7:0]  en_reg;
	logic [2:0]  txs_err_reg;
	logic [1:0]  tx_cnt_reg;
	logic [7:0]  rxs_reg;
	logic [7:0]  int_reg;
	logic [2:0]  txpol_reg;
	logic [7:0]  rxpol_reg;
	logic        sym_mode_reg;
	logic [15:0] maxlen_reg;
	logic [4:0]  col_cnt_reg;
	logic        rx_media_acc_reg;
	logic        rx_ovr_acc_reg;
	logic        wr_pend_reg;
	logic [7:0]  wr_addr_reg;
	logic        irq_reg;
	logic [31:0] hrdata_reg;
	logic        push_reg;
	logic [7:0]  push_byte_reg;
	logic        hready_reg;
	logic        hresp_reg;

	logic        acc;
	logic        rd;
	logic        rd_txs;
	logic        rd_rxs;
	logic        rd_int;
	logic [7:0]  int_view;
	logic [2:0]  tx_ev;
	logic [7:0]  rx_ev;
	logic        rx_pass;
	logic        media_now;
	logic        ovr_now;
	logic [31:0] rd_mux;

	// Address phase decode
	assign acc    = hsel && hready && htrans[1];
	assign rd     = acc && !hwrite;
	assign rd_txs = rd && (haddr[7:0] == pesi_pkg::OFS_TXS);
	assign rd_rxs = rd && (haddr[7:0] == pesi_pkg::OFS_RXS);
	assign rd_int = rd && (haddr[7:0] == pesi_pkg::OFS_INT);

	// Summary bits follow their status registers
	always_comb begin
		int_view = int_reg;
		int_view[pesi_pkg::B_TRANSMIT_FAULT_SUMMARY] = |txs_err_reg;
		int_view[pesi_pkg::B_RECEIVE_EVENT_SUMMARY] = |rxs_reg;
	end

	always_comb begin
		unique case (haddr[7:0])
			pesi_pkg::OFS_EN:     rd_mux = {24'h000000, en_reg};
			pesi_pkg::OFS_TXS:    rd_mux = {24'h000000, tx_cnt_reg, 3'h0, txs_err_reg};
			pesi_pkg::OFS_RXS:    rd_mux = {24'h000000, rxs_reg};
			pesi_pkg::OFS_INT:    rd_mux = {24'h000000, int_view};
			pesi_pkg::OFS_TXPOL:  rd_mux = {29'h00000000, txpol_reg};
			pesi_pkg::OFS_RXPOL:  rd_mux = {24'h000000, rxpol_reg};
			pesi_pkg::OFS_MODE:   rd_mux = {31'h00000000, sym_mode_reg};
			pesi_pkg::OFS_MAXLEN: rd_mux = {16'h0000, maxlen_reg};
			default:              rd_mux = 32'h00000000;
		endcase
	end

	// Bus slave: zero wait states, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_reg  <= 32'h00000000;
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			hready_reg  <= 1'b0;
			hresp_reg   <= 1'b0;
		end else begin
			hready_reg <= 1'b1;
			hresp_reg  <= 1'b0;
			if (rd)
				hrdata_reg <= rd_mux;
			wr_pend_reg <= acc && hwrite;
			if (acc)
				wr_addr_reg <= haddr[7:0];
		end
	end

	// Software-written configuration
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			en_reg       <= pesi_pkg::RST_BYTE;
			txpol_reg    <= 3'h0;
			rxpol_reg    <= pesi_pkg::RST_BYTE;
			sym_mode_reg <= 1'b0;
			maxlen_reg   <= pesi_pkg::RST_MAXLEN;
		end else if (wr_pend_reg) begin
			unique case (wr_addr_reg)
				pesi_pkg::OFS_EN:     en_reg <= hwdata[7:0] & pesi_pkg::EN_MASK;
				pesi_pkg::OFS_TXPOL:  txpol_reg <= hwdata[2:0];
				pesi_pkg::OFS_RXPOL:  rxpol_reg <= hwdata[7:0] & pesi_pkg::RXS_MASK;
				pesi_pkg::OFS_MODE:   sym_mode_reg <= hwdata[0];
				pesi_pkg::OFS_MAXLEN: maxlen_reg <= hwdata[15:0];
				default:              ;
			endcase
		end
	end

	// Transmit FIFO packet count
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			tx_cnt_reg <= 2'h0;
		else if (tx_first_byte_load && !tx_packet_done && tx_cnt_reg < pesi_pkg::TX_CNT_MAX)
			tx_cnt_reg <= tx_cnt_reg + 2'h1;
		else if (tx_packet_done && !tx_first_byte_load && tx_cnt_reg != 2'h0)
			tx_cnt_reg <= tx_cnt_reg - 2'h1;
	end

	// Consecutive collisions of the current packet
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			col_cnt_reg <= 5'h00;
		else if (tx_packet_done || tx_ev[pesi_pkg::TX_XCL])
			col_cnt_reg <= 5'h00;
		else if (tx_collision && !tx_past_64_bytes)
			col_cnt_reg <= col_cnt_reg + 5'h01;
	end

	assign tx_ev[pesi_pkg::TX_XCL] = tx_collision && !tx_past_64_bytes
		&& col_cnt_reg == pesi_pkg::XCOL_LAST;
	assign tx_ev[pesi_pkg::TX_LCL] = tx_collision && tx_past_64_bytes;
	assign tx_ev[pesi_pkg::TX_UNF] = tx_fifo_starved && tx_past_64_bytes;

	// Transmit error bits; a new error beats the read clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			txs_err_reg <= 3'h0;
		else
			txs_err_reg <= (rd_txs ? 3'h0 : txs_err_reg) | (tx_ev & txpol_reg);
	end

	// Media and overrun conditions gathered over the frame
	assign media_now = rx_active && (sym_mode_reg ? rx_symbol_err : rx_mii_err);
	assign ovr_now   = rx_active && rx_fifo_no_space;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_media_acc_reg <= 1'b0;
			rx_ovr_acc_reg   <= 1'b0;
		end else if (rx_frame_end) begin
			rx_media_acc_reg <= 1'b0;
			rx_ovr_acc_reg   <= 1'b0;
		end else begin
			rx_media_acc_reg <= rx_media_acc_reg | media_now;
			rx_ovr_acc_reg   <= rx_ovr_acc_reg | ovr_now;
		end
	end

	always_comb begin
		rx_ev = 8'h00;
		rx_ev[pesi_pkg::RX_PAUSE] = rx_pause_frame;
		rx_ev[pesi_pkg::RX_MEDIA] = rx_media_acc_reg | media_now;
		rx_ev[pesi_pkg::RX_LONG]  = rx_length > maxlen_reg;
		rx_ev[pesi_pkg::RX_RUNT]  = rx_length < pesi_pkg::RUNT_LEN;
		rx_ev[pesi_pkg::RX_ALIGN] = rx_crc_err && rx_framing_err;
		rx_ev[pesi_pkg::RX_CRC]   = rx_crc_err && !rx_framing_err;
		rx_ev[pesi_pkg::RX_OVR]   = rx_ovr_acc_reg | ovr_now;
	end

	assign rx_pass = (rx_ev & ~rxpol_reg) == 8'h00;

	// Receive status, set at packet end; a new set beats the read clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			rxs_reg <= pesi_pkg::RST_BYTE;
		else
			rxs_reg <= (rd_rxs ? 8'h00 : rxs_reg)
				| ((rx_frame_end && rx_pass) ? rx_ev : 8'h00);
	end

	// Status byte trails the packet's last data
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			push_reg      <= 1'b0;
			push_byte_reg <= 8'h00;
		end else begin
			push_reg <= rx_frame_end;
			if (rx_frame_end)
				push_byte_reg <= rx_pass ? rx_ev : 8'h00;
		end
	end

	// Sticky event bits, set only where enabled
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			int_reg <= pesi_pkg::RST_BYTE;
		else begin
			int_reg[pesi_pkg::B_STOP] <= (int_reg[pesi_pkg::B_STOP] && !rd_int)
				| (port_stopped && en_reg[pesi_pkg::B_STOP]);
			int_reg[pesi_pkg::B_OVFC] <= (int_reg[pesi_pkg::B_OVFC] && !rd_int)
				| (counter_saturated && en_reg[pesi_pkg::B_OVFC]);
			int_reg[pesi_pkg::B_LNCH] <= (int_reg[pesi_pkg::B_LNCH] && !rd_int)
				| (link_changed && en_reg[pesi_pkg::B_LNCH]);
			int_reg[pesi_pkg::B_TXOK] <= (int_reg[pesi_pkg::B_TXOK] && !rd_int)
				| (tx_packet_done && en_reg[pesi_pkg::B_TXOK]);
			int_reg[pesi_pkg::B_RXOK] <= (int_reg[pesi_pkg::B_RXOK] && !rd_int)
				| (rx_frame_end && rx_ev == 8'h00 && en_reg[pesi_pkg::B_RXOK]);
			int_reg[pesi_pkg::B_TRANSMIT_FAULT_SUMMARY] <= 1'b0;
			int_reg[pesi_pkg::B_RECEIVE_EVENT_SUMMARY] <= 1'b0;
			int_reg[7]                <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			irq_reg <= 1'b0;
		else
			irq_reg <= |(int_view & en_reg);
	end

	assign hrdata         = hrdata_reg;
	assign hreadyout      = hready_reg;
	assign hresp          = hresp_reg;
	assign rx_status_push = push_reg;
	assign rx_status_byte = push_byte_reg;
	assign port_irq       = irq_reg;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_frame_end;
		rx_frame_end;
	endsequence

	sequence s_push_out(logic [7:0] b);
		rx_status_push && rx_status_byte == b;
	endsequence

	chk_irq_quiet: assert property ((int_view & en_reg) == 8'h00 |=> !port_irq)
		else $error("interrupt raised with no enabled status bit");
	chk_irq_raise: assert property ((int_view & en_reg) != 8'h00 |=> port_irq)
		else $error("interrupt missing for enabled status bit");
	chk_pkt_count_max: assert property (tx_cnt_reg <= 2'h2)
		else $error("transmit packet count above two");
	chk_pkt_count_inc: assert property (tx_first_byte_load && !tx_packet_done && tx_cnt_reg == 2'h0
		|=> tx_cnt_reg == 2'h1)
		else $error("packet count did not rise on first byte");
	chk_txs_read_count: assert property (rd_txs && !tx_first_byte_load && !tx_packet_done
		|=> $stable(tx_cnt_reg))
		else $error("packet count changed by status read");
	chk_txs_read_clear: assert property (rd_txs && tx_ev == 3'h0 |=> txs_err_reg == 3'h0)
		else $error("transmit errors survived status read");
	chk_tx_policy_gate: assert property ($rose(txs_err_reg[pesi_pkg::TX_LCL])
		|-> $past(txpol_reg[pesi_pkg::TX_LCL]))
		else $error("late collision flagged without stop policy");
	chk_late_collision: assert property (tx_collision && tx_past_64_bytes && txpol_reg[pesi_pkg::TX_LCL]
		|=> txs_err_reg[pesi_pkg::TX_LCL])
		else $error("late collision not flagged");
	chk_rx_filter_block: assert property (rx_frame_end && !rx_pass && !rd_rxs |=> $stable(rxs_reg))
		else $error("status set for packet with blocked event");
	chk_rx_read_clear: assert property (rd_rxs && !rx_frame_end |=> rxs_reg == 8'h00)
		else $error("receive status survived read");
	chk_rx_status_push: assert property (s_frame_end ##0 rx_pass
		|=> s_push_out($past(rx_ev)))
		else $error("status byte not pushed after packet end");
	chk_rx_push_blocked: assert property (s_frame_end ##0 !rx_pass |=> s_push_out(8'h00))
		else $error("blocked packet pushed a nonzero status byte");
	chk_receive_event_summary_after_end: assert property ($rose(int_view[pesi_pkg::B_RECEIVE_EVENT_SUMMARY]) |-> $past(rx_frame_end))
		else $error("receive event summary set before packet end");
	chk_pkt_count_dec: assert property (tx_packet_done && !tx_first_byte_load && tx_cnt_reg == 2'h2
		|=> tx_cnt_reg == 2'h1)
		else $error("packet count did not fall after transmission");
	chk_excess_collision: assert property (tx_ev[pesi_pkg::TX_XCL] && txpol_reg[pesi_pkg::TX_XCL]
		|=> txs_err_reg[pesi_pkg::TX_XCL])
		else $error("excessive collision not flagged");
	chk_underrun_flag: assert property (tx_fifo_starved && tx_past_64_bytes && txpol_reg[pesi_pkg::TX_UNF]
		|=> txs_err_reg[pesi_pkg::TX_UNF])
		else $error("transmit underrun not flagged");
	chk_stop_gate: assert property (!en_reg[pesi_pkg::B_STOP] && !int_reg[pesi_pkg::B_STOP]
		|=> !int_reg[pesi_pkg::B_STOP])
		else $error("port stop flagged while disabled");
	chk_rxok_gate: assert property (rx_frame_end && rx_ev == 8'h00 && en_reg[pesi_pkg::B_RXOK]
		|=> int_reg[pesi_pkg::B_RXOK])
		else $error("clean packet did not flag receive done");
	chk_rx_runt_flag: assert property (s_frame_end ##0 (rx_pass && rx_length < pesi_pkg::RUNT_LEN)
		|=> rxs_reg[pesi_pkg::RX_RUNT])
		else $error("short packet not flagged");
	chk_rx_align_flag: assert property (s_frame_end ##0 (rx_pass && rx_crc_err && rx_framing_err)
		|=> rxs_reg[pesi_pkg::RX_ALIGN])
		else $error("alignment error not flagged");
	chk_transmit_fault_summary_summary: assert property (int_view[pesi_pkg::B_TRANSMIT_FAULT_SUMMARY] == (|txs_err_reg))
		else $error("transmit error summary mismatch");
endmodule

// [verif/tb_top.sv]
// Self-checking bench for the port event status and interrupt block.
// Assumes the block is the only AHB-Lite slave, so hready follows hreadyout.
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [15:0] drv = 16'h0;
	logic [15:0] rxlen = 16'h0;
	logic        rx_status_push;
	logic [7:0]  rx_status_byte;
	logic        port_irq;
	logic [31:0] rd;
	int          fails = 0;
	int          total_checks = 0;
	// Event input positions inside drv
	localparam logic [15:0] E_STOP = 16'h0001, E_OVFC = 16'h0002, E_LNCH = 16'h0004, E_LOAD = 16'h0008;
	localparam logic [15:0] E_DONE = 16'h0010, E_COL = 16'h0020, E_P64 = 16'h0040, E_STARVE = 16'h0080;
	localparam logic [15:0] E_ACT = 16'h0100, E_SYM = 16'h0200, E_MII = 16'h0400, E_NOSP = 16'h0800;
	localparam logic [15:0] E_END = 16'h1000, E_PAUSE = 16'h2000, E_CRC = 16'h4000, E_FRM = 16'h8000;
	logic [15:0] rv [10] = '{E_PAUSE, E_MII, E_SYM, 16'h0, 16'h0, 16'h0, E_CRC | E_FRM, E_CRC, E_NOSP, 16'h0};
	logic [15:0] rl [10] = '{16'h0040, 16'h0040, 16'h0040, 16'h05ef, 16'h05ee, 16'h003f, 16'h0040, 16'h0040,
		16'h0040, 16'h0040};
	logic [7:0]  re [10] = '{8'h80, 8'h20, 8'h00, 8'h10, 8'h00, 8'h08, 8'h04, 8'h02, 8'h01, 8'h00};
	logic [15:0] ev [4] = '{E_STOP, E_OVFC, E_LNCH, E_DONE};
	logic [7:0]  eb [4] = '{8'h40, 8'h20, 8'h10, 8'h04};

	always #4 hclk = ~hclk;

	pesi_port_events dut_u (
		.hclk               (hclk),
		.hresetn            (hresetn),
		.hsel               (hsel),
		.haddr              (haddr),
		.htrans             (htrans),
		.hwrite             (hwrite),
		.hsize              (3'h2),
		.hwdata             (hwdata),
		.hready             (hreadyout),
		.hrdata             (hrdata),
		.hreadyout          (hreadyout),
		.hresp              (hresp),
		.port_stopped       (drv[0]),
		.counter_saturated  (drv[1]),
		.link_changed       (drv[2]),
		.tx_first_byte_load (drv[3]),
		.tx_packet_done     (drv[4]),
		.tx_collision       (drv[5]),
		.tx_past_64_bytes   (drv[6]),
		.tx_fifo_starved    (drv[7]),
		.rx_active          (drv[8]),
		.rx_symbol_err      (drv[9]),
		.rx_mii_err         (drv[10]),
		.rx_fifo_no_space   (drv[11]),
		.rx_frame_end       (drv[12]),
		.rx_pause_frame     (drv[13]),
		.rx_crc_err         (drv[14]),
		.rx_framing_err     (drv[15]),
		.rx_length          (rxlen),
		.rx_status_push     (rx_status_push),
		.rx_status_byte     (rx_status_byte),
		.port_irq           (port_irq)
	);

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One single transfer: address phase, then data phase
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	task automatic pulse(input logic [15:0] v, input int n);
		repeat (n) begin
			@(posedge hclk);
			drv <= v;
			@(posedge hclk);
			drv <= 16'h0;
		end
	endtask

	task automatic irqchk(input logic exp);
		@(posedge hclk);
		#1;
		chk({31'h0, port_irq}, {31'h0, exp});
	endtask

	// Received packet ends; status byte must follow the last data
	task automatic frame(input logic [15:0] v, input logic [15:0] len, input logic [7:0] exp);
		@(posedge hclk);
		drv <= v | E_ACT | E_END;
		rxlen <= len;
		@(posedge hclk);
		drv <= 16'h0;
		#1;
		chk({31'h0, rx_status_push}, 32'h1);
		chk({24'h0, rx_status_byte}, {24'h0, exp});
		@(posedge hclk);
		#1;
		chk({31'h0, rx_status_push}, 32'h0);
	endtask

	task automatic finish_test;
		$display("checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge hclk);
		fails++;
		finish_test();
	end

	initial begin
		repeat (12) @(posedge hclk);
		chk({31'h0, hreadyout}, 32'h0);
		chk({31'h0, port_irq}, 32'h0);
		chk({31'h0, rx_status_push}, 32'h0);
		hresetn <= 1'b1;
		rdchk(pesi_pkg::OFS_EN, 32'h0);
		rdchk(pesi_pkg::OFS_TXS, 32'h0);
		rdchk(pesi_pkg::OFS_RXS, 32'h0);
		rdchk(pesi_pkg::OFS_MAXLEN, 32'h05ee);
		wr(pesi_pkg::OFS_EN, 32'hff);
		rdchk(pesi_pkg::OFS_EN, 32'h7f);
		wr(pesi_pkg::OFS_TXS, 32'hff);
		rdchk(pesi_pkg::OFS_TXS, 32'h0);
		rdchk(8'h20, 32'h0);
		$display("test registers done");
		for (int i = 0; i < 4; i++) begin
			wr(pesi_pkg::OFS_EN, 32'h0);
			pulse(ev[i], 1);
			rdchk(pesi_pkg::OFS_INT, 32'h0);
			wr(pesi_pkg::OFS_EN, {24'h0, eb[i]});
			pulse(ev[i], 1);
			irqchk(1'b1);
			rdchk(pesi_pkg::OFS_INT, {24'h0, eb[i]});
			irqchk(1'b0);
		end
		$display("test enables done");
		wr(pesi_pkg::OFS_EN, 32'h08);
		wr(pesi_pkg::OFS_TXPOL, 32'h0);
		pulse(E_STARVE | E_P64, 1);
		rdchk(pesi_pkg::OFS_TXS, 32'h0);
		rdchk(pesi_pkg::OFS_INT, 32'h0);
		wr(pesi_pkg::OFS_TXPOL, 32'h7);
		pulse(E_STARVE, 1);
		rdchk(pesi_pkg::OFS_TXS, 32'h0);
		pulse(E_STARVE | E_P64, 1);
		rdchk(pesi_pkg::OFS_INT, 32'h08);
		rdchk(pesi_pkg::OFS_INT, 32'h08);
		irqchk(1'b1);
		rdchk(pesi_pkg::OFS_TXS, 32'h01);
		rdchk(pesi_pkg::OFS_TXS, 32'h0);
		rdchk(pesi_pkg::OFS_INT, 32'h0);
		pulse(E_COL | E_P64, 1);
		rdchk(pesi_pkg::OFS_TXS, 32'h02);
		pulse(E_COL, 15);
		rdchk(pesi_pkg::OFS_TXS, 32'h0);
		pulse(E_COL, 1);
		rdchk(pesi_pkg::OFS_TXS, 32'h04);
		pulse(E_LOAD, 3);
		rdchk(pesi_pkg::OFS_TXS, 32'h80);
		rdchk(pesi_pkg::OFS_TXS, 32'h80);
		pulse(E_DONE, 1);
		rdchk(pesi_pkg::OFS_TXS, 32'h40);
		pulse(E_DONE | E_LOAD, 1);
		rdchk(pesi_pkg::OFS_TXS, 32'h40);
		pulse(E_DONE, 1);
		rdchk(pesi_pkg::OFS_TXS, 32'h0);
		$display("test transmit done");
		wr(pesi_pkg::OFS_EN, 32'h03);
		wr(pesi_pkg::OFS_RXPOL, 32'hbf);
		for (int i = 0; i < 10; i++) begin
			frame(rv[i], rl[i], re[i]);
			rdchk(pesi_pkg::OFS_RXS, {24'h0, re[i]});
			rdchk(pesi_pkg::OFS_RXS, 32'h0);
		end
		wr(pesi_pkg::OFS_MAXLEN, 32'h0100);
		rdchk(pesi_pkg::OFS_MAXLEN, 32'h0100);
		frame(16'h0, 16'h0101, 8'h10);
		rdchk(pesi_pkg::OFS_RXS, 32'h10);
		rdchk(pesi_pkg::OFS_INT, 32'h01);
		wr(pesi_pkg::OFS_MODE, 32'h1);
		frame(E_MII, 16'h0040, 8'h00);
		frame(E_SYM, 16'h0040, 8'h20);
		rdchk(pesi_pkg::OFS_INT, 32'h03);
		rdchk(pesi_pkg::OFS_INT, 32'h02);
		irqchk(1'b1);
		rdchk(pesi_pkg::OFS_RXS, 32'h20);
		rdchk(pesi_pkg::OFS_INT, 32'h0);
		irqchk(1'b0);
		wr(pesi_pkg::OFS_RXPOL, 32'h02);
		frame(E_CRC, 16'h003f, 8'h00);
		frame(E_CRC, 16'h0040, 8'h02);
		rdchk(pesi_pkg::OFS_RXS, 32'h02);
		wr(pesi_pkg::OFS_RXPOL, 32'h0);
		frame(E_PAUSE, 16'h0040, 8'h00);
		rdchk(pesi_pkg::OFS_RXS, 32'h0);
		$display("test receive done");
		finish_test();
	end
endmodule
